// File: hw/lso_pkg.sv
/*
 * Package for the limit switch output: register offsets, reset values,
 * timing constants, mode enumerations and the configuration carrier.
 * Assumes a 40 MHz system clock and a word-wide register port.
 */
package lso_pkg;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int          CLK_PERIOD_NS   = 25;
   localparam int          DLY_UNIT_NS     = 100_000_000;
   localparam int          DLY_UNIT_CYCLES = DLY_UNIT_NS / CLK_PERIOD_NS;
   localparam int          DLY_MAX_S_X10   = 1000;
   localparam int          DLY_W           = 10;
   localparam logic [9:0]  DLY_MAX         = 10'(DLY_MAX_S_X10);
   localparam logic [9:0]  DLY_RST         = 10'h000;

   // ==========================================================
   // Register map
   // ==========================================================
   localparam int          ADDR_W          = 4;
   localparam int          DATA_W          = 32;
   localparam logic [3:0]  OFS_CTRL        = 4'h0;
   localparam logic [3:0]  OFS_ON_VAL      = 4'h1;
   localparam logic [3:0]  OFS_OFF_VAL     = 4'h2;
   localparam logic [3:0]  OFS_ON_DLY      = 4'h3;
   localparam logic [3:0]  OFS_OFF_DLY     = 4'h4;
   localparam logic [3:0]  OFS_STATUS      = 4'h5;
   localparam int          CTRL_FUNC_LSB   = 0;
   localparam int          CTRL_FAIL_LSB   = 4;
   localparam int          CTRL_INV_BIT    = 8;
   localparam int          STS_OUT_BIT     = 0;
   localparam int          STS_LIM_BIT     = 1;
   localparam int          STS_ERR_BIT     = 2;
   localparam logic [31:0] THR_RST         = 32'h0000_0000;

   // ==========================================================
   // Modes
   // ==========================================================
   typedef enum logic [2:0] {
      FN_OFF,
      FN_ON,
      FN_DIAG,
      FN_LIMIT,
      FN_DIGITAL
   } lso_func_t;

   typedef enum logic [1:0] {
      FAIL_ACTUAL,
      FAIL_OPEN,
      FAIL_CLOSED
   } lso_fail_t;

   typedef struct packed {
      lso_func_t func;
      lso_fail_t fail;
      logic      invert;
   } lso_cfg_t;

   localparam lso_cfg_t CFG_RST = '{func: FN_OFF, fail: FAIL_OPEN, invert: 1'b0};

endpackage : lso_pkg

// File: hw/lso_delay_timer.sv
/*
 * One delay timer for the limit switch output, counting slow ticks while armed.
 * Assumes a shared tick pulse of one cycle and a synchronous active high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module lso_delay_timer (
   input  wire logic       i_sys_clk,
   input  wire logic       i_srst,
   input  wire logic       i_arm,
   input  wire logic       i_tick,
   input  wire logic [9:0] i_limit,
   output logic            o_done
);

   logic [9:0] count_r;
   logic [9:0] count_nxt;

   // ==========================================================
   // Counter
   // ==========================================================
   always_comb begin
      count_nxt = count_r;
      if (!i_arm) begin
         count_nxt = 10'h000;
      end else if (i_tick && (count_r < i_limit)) begin
         count_nxt = 10'(count_r + 10'h001);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         count_r <= 10'h000;
      end else begin
         count_r <= count_nxt;
      end
   end

   // A zero limit completes in the arming cycle itself.
   assign o_done = i_arm && (count_r >= i_limit);

   property p_drop_clears;
      @(posedge i_sys_clk) disable iff (i_srst)
         !i_arm |=> (count_r == 10'h000);
   endproperty
   a_drop_clears: assert property (p_drop_clears) else $error("Timer not cleared after disarm.");

endmodule : lso_delay_timer

`default_nettype wire

// File: hw/lso_top.sv
/*
 * Limit switch output: thresholds with hysteresis, switch delays, failure
 * state, inversion and a small register port.
 * Assumes inputs synchronous to i_sys_clk and a signed measured value.
 */
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module lso_top #(
   parameter int TICK_CYCLES = lso_pkg::DLY_UNIT_CYCLES
) (
   input  wire logic        i_sys_clk,
   input  wire logic        i_srst,
   input  wire logic [3:0]  i_addr,
   input  wire logic [31:0] i_wr_data,
   input  wire logic        i_wr_en,
   input  wire logic        i_rd_en,
   input  wire logic [31:0] i_meas_value,
   input  wire logic        i_error,
   input  wire logic        i_diag_event,
   input  wire logic        i_dig_out,
   output logic [31:0]      o_rd_data,
   output logic             o_switch_closed
);

   // ==========================================================
   // State
   // ==========================================================
   lso_pkg::lso_cfg_t  cfg_r;
   lso_pkg::lso_cfg_t  cfg_nxt;
   logic signed [31:0] on_val_r;
   logic signed [31:0] on_val_nxt;
   logic signed [31:0] off_val_r;
   logic signed [31:0] off_val_nxt;
   logic [9:0]         on_dly_r;
   logic [9:0]         on_dly_nxt;
   logic [9:0]         off_dly_r;
   logic [9:0]         off_dly_nxt;
   logic [31:0]        tick_cnt_r;
   logic [31:0]        tick_cnt_nxt;
   logic               tick;
   logic               limit_closed_r;
   logic               limit_closed_nxt;
   logic               switch_r;
   logic               switch_nxt;
   logic [31:0]        rd_data_r;
   logic [31:0]        rd_data_nxt;
   logic signed [31:0] meas;
   logic               on_above;
   logic               close_req;
   logic               open_req;
   logic               is_limit;
   logic               raw_out;
   logic [1:0]         arm;
   logic [9:0]         lim [2];
   logic [1:0]         done;

   assign meas = i_meas_value;

   // ==========================================================
   // Register writes
   // ==========================================================
   always_comb begin
      cfg_nxt     = cfg_r;
      on_val_nxt  = on_val_r;
      off_val_nxt = off_val_r;
      on_dly_nxt  = on_dly_r;
      off_dly_nxt = off_dly_r;
      if (i_wr_en) begin
         case (i_addr)
            lso_pkg::OFS_CTRL: begin
               // Unknown codes leave the field unchanged rather than enter an undefined mode.
               if (i_wr_data[lso_pkg::CTRL_FUNC_LSB +: 3] <= 3'(lso_pkg::FN_DIGITAL)) begin
                  cfg_nxt.func = lso_pkg::lso_func_t'(i_wr_data[lso_pkg::CTRL_FUNC_LSB +: 3]);
               end
               if (i_wr_data[lso_pkg::CTRL_FAIL_LSB +: 2] <= 2'(lso_pkg::FAIL_CLOSED)) begin
                  cfg_nxt.fail = lso_pkg::lso_fail_t'(i_wr_data[lso_pkg::CTRL_FAIL_LSB +: 2]);
               end
               cfg_nxt.invert = i_wr_data[lso_pkg::CTRL_INV_BIT];
            end
            lso_pkg::OFS_ON_VAL: begin
               on_val_nxt = i_wr_data;
            end
            lso_pkg::OFS_OFF_VAL: begin
               off_val_nxt = i_wr_data;
            end
            lso_pkg::OFS_ON_DLY: begin
               // Values beyond the range clamp to the longest delay.
               on_dly_nxt = (i_wr_data > 32'(lso_pkg::DLY_MAX)) ? lso_pkg::DLY_MAX : i_wr_data[9:0];
            end
            lso_pkg::OFS_OFF_DLY: begin
               off_dly_nxt = (i_wr_data > 32'(lso_pkg::DLY_MAX)) ? lso_pkg::DLY_MAX : i_wr_data[9:0];
            end
            default: begin
               cfg_nxt = cfg_r;
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         cfg_r     <= lso_pkg::CFG_RST;
         on_val_r  <= lso_pkg::THR_RST;
         off_val_r <= lso_pkg::THR_RST;
         on_dly_r  <= lso_pkg::DLY_RST;
         off_dly_r <= lso_pkg::DLY_RST;
      end else begin
         cfg_r     <= cfg_nxt;
         on_val_r  <= on_val_nxt;
         off_val_r <= off_val_nxt;
         on_dly_r  <= on_dly_nxt;
         off_dly_r <= off_dly_nxt;
      end
   end

   // ==========================================================
   // Tenth-second tick
   // ==========================================================
   always_comb begin
      tick         = (tick_cnt_r == 32'(TICK_CYCLES - 1));
      tick_cnt_nxt = tick ? 32'h0000_0000 : 32'(tick_cnt_r + 32'h0000_0001);
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         tick_cnt_r <= 32'h0000_0000;
      end else begin
         tick_cnt_r <= tick_cnt_nxt;
      end
   end

   // ==========================================================
   // Threshold comparison and delays
   // ==========================================================
   always_comb begin
      is_limit = (cfg_r.func == lso_pkg::FN_LIMIT);
      on_above = (on_val_r > off_val_r);
      if (on_above) begin
         close_req = (meas > on_val_r);
         open_req  = (meas < off_val_r);
      end else begin
         close_req = (meas < on_val_r);
         open_req  = (meas > off_val_r);
      end
      arm[0] = is_limit && !limit_closed_r && close_req;
      arm[1] = is_limit && limit_closed_r && open_req;
      lim[0] = on_dly_r;
      lim[1] = off_dly_r;
   end

   // The tick runs free, so a programmed delay of N lasts between N-1 and N tenths.
   for (genvar g = 0; g < 2; g++) begin : g_timer
      lso_delay_timer u_timer (
         .i_sys_clk (i_sys_clk),
         .i_srst    (i_srst),
         .i_arm     (arm[g]),
         .i_tick    (tick),
         .i_limit   (lim[g]),
         .o_done    (done[g])
      );
   end

   always_comb begin
      limit_closed_nxt = limit_closed_r;
      if (!is_limit) begin
         limit_closed_nxt = 1'b0;
      end else if (done[0]) begin
         limit_closed_nxt = 1'b1;
      end else if (done[1]) begin
         limit_closed_nxt = 1'b0;
      end
   end

   // ==========================================================
   // Output function, failure state and inversion
   // ==========================================================
   always_comb begin
      case (cfg_r.func)
         lso_pkg::FN_OFF:     raw_out = 1'b0;
         lso_pkg::FN_ON:      raw_out = 1'b1;
         lso_pkg::FN_DIAG:    raw_out = !i_diag_event;
         lso_pkg::FN_LIMIT:   raw_out = limit_closed_r;
         lso_pkg::FN_DIGITAL: raw_out = i_dig_out;
         default:             raw_out = 1'b0;
      endcase
      if (i_error && (is_limit || (cfg_r.func == lso_pkg::FN_DIGITAL))) begin
         case (cfg_r.fail)
            lso_pkg::FAIL_OPEN:   raw_out = 1'b0;
            lso_pkg::FAIL_CLOSED: raw_out = 1'b1;
            default:              raw_out = raw_out;
         endcase
      end
      switch_nxt = raw_out ^ cfg_r.invert;
   end

   // ==========================================================
   // Read port
   // ==========================================================
   always_comb begin
      rd_data_nxt = 32'h0000_0000;
      if (i_rd_en) begin
         case (i_addr)
            lso_pkg::OFS_CTRL: begin
               rd_data_nxt[lso_pkg::CTRL_FUNC_LSB +: 3] = cfg_r.func;
               rd_data_nxt[lso_pkg::CTRL_FAIL_LSB +: 2] = cfg_r.fail;
               rd_data_nxt[lso_pkg::CTRL_INV_BIT]       = cfg_r.invert;
            end
            lso_pkg::OFS_ON_VAL:  rd_data_nxt = on_val_r;
            lso_pkg::OFS_OFF_VAL: rd_data_nxt = off_val_r;
            lso_pkg::OFS_ON_DLY:  rd_data_nxt[9:0] = on_dly_r;
            lso_pkg::OFS_OFF_DLY: rd_data_nxt[9:0] = off_dly_r;
            lso_pkg::OFS_STATUS: begin
               rd_data_nxt[lso_pkg::STS_OUT_BIT] = switch_r;
               rd_data_nxt[lso_pkg::STS_LIM_BIT] = limit_closed_r;
               rd_data_nxt[lso_pkg::STS_ERR_BIT] = i_error;
            end
            default: rd_data_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         limit_closed_r <= 1'b0;
         switch_r       <= 1'b0;
         rd_data_r      <= 32'h0000_0000;
      end else begin
         limit_closed_r <= limit_closed_nxt;
         switch_r       <= switch_nxt;
         rd_data_r      <= rd_data_nxt;
      end
   end

   assign o_switch_closed = switch_r;
   assign o_rd_data       = rd_data_r;

   // ==========================================================
   // Checks
   // ==========================================================
   sequence s_limit_quiet;
      is_limit && !i_wr_en;
   endsequence

   property p_close_above;
      @(posedge i_sys_clk) disable iff (i_srst)
         s_limit_quiet ##0 (on_val_r > off_val_r && meas > on_val_r && on_dly_r == 10'h000) |=> limit_closed_r;
   endproperty
   a_close_above: assert property (p_close_above) else $error("Did not close above on-threshold.");

   property p_open_below;
      @(posedge i_sys_clk) disable iff (i_srst)
         s_limit_quiet ##0 (on_val_r > off_val_r && meas < off_val_r && off_dly_r == 10'h000) |=> !limit_closed_r;
   endproperty
   a_open_below: assert property (p_open_below) else $error("Did not open below off-threshold.");

   property p_close_below;
      @(posedge i_sys_clk) disable iff (i_srst)
         s_limit_quiet ##0 (on_val_r < off_val_r && meas < on_val_r && on_dly_r == 10'h000) |=> limit_closed_r;
   endproperty
   a_close_below: assert property (p_close_below) else $error("Did not close below on-threshold.");

   property p_open_above;
      @(posedge i_sys_clk) disable iff (i_srst)
         s_limit_quiet ##0 (on_val_r < off_val_r && meas > off_val_r && off_dly_r == 10'h000) |=> !limit_closed_r;
   endproperty
   a_open_above: assert property (p_open_above) else $error("Did not open above off-threshold.");

   property p_thr_reset;
      @(posedge i_sys_clk)
         $past(i_srst) |-> (on_val_r == 32'h0000_0000 && off_val_r == 32'h0000_0000 && !cfg_r.invert);
   endproperty
   a_thr_reset: assert property (p_thr_reset) else $error("Thresholds or inversion not cleared by reset.");

   property p_close_needs_delay;
      @(posedge i_sys_clk) disable iff (i_srst)
         $rose(limit_closed_r) |-> $past(done[0]) && ($past(on_dly_r) == 10'h000 || $past(tick, 2));
   endproperty
   a_close_needs_delay: assert property (p_close_needs_delay) else $error("Closed without switch-on delay.");

   property p_open_needs_delay;
      @(posedge i_sys_clk) disable iff (i_srst)
         $fell(limit_closed_r) && $past(is_limit) |-> $past(done[1]);
   endproperty
   a_open_needs_delay: assert property (p_open_needs_delay) else $error("Opened without switch-off delay.");

   property p_fail_state;
      @(posedge i_sys_clk) disable iff (i_srst)
         (i_error && is_limit && cfg_r.fail != lso_pkg::FAIL_ACTUAL)
            |=> (o_switch_closed == (($past(cfg_r.fail) == lso_pkg::FAIL_CLOSED) ^ $past(cfg_r.invert)));
   endproperty
   a_fail_state: assert property (p_fail_state) else $error("Failure state not applied.");

   property p_fail_scope;
      @(posedge i_sys_clk) disable iff (i_srst)
         (cfg_r.func == lso_pkg::FN_ON) |=> (o_switch_closed == !$past(cfg_r.invert));
   endproperty
   a_fail_scope: assert property (p_fail_scope) else $error("On function disturbed by error.");

   property p_status_read;
      @(posedge i_sys_clk) disable iff (i_srst)
         (i_rd_en && i_addr == lso_pkg::OFS_STATUS) |=> (o_rd_data[lso_pkg::STS_OUT_BIT] == $past(o_switch_closed));
   endproperty
   a_status_read: assert property (p_status_read) else $error("Status does not show output state.");

   property p_band_hold;
      @(posedge i_sys_clk) disable iff (i_srst)
         (is_limit && !close_req && !open_req) ##1 is_limit |-> $stable(limit_closed_r);
   endproperty
   a_band_hold: assert property (p_band_hold) else $error("State changed inside hysteresis band.");

endmodule : lso_top

`default_nettype wire

// File: verification/lso_load_model.sv
/*
 * Behavioural model of the external load wired to the switch contact.
 * Assumes the contact level of the limit switch output, 1 = closed, and the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

module lso_load_model (
   input  wire logic        i_sys_clk,
   input  wire logic        i_srst,
   input  wire logic        i_contact,
   output logic             o_energized,
   output logic [15:0]      o_n_ops
);
   logic prev_r;

   // ==========================================================
   // Load
   // ==========================================================
   // A resistive load follows the contact at once; an open contact leaves it unpowered.
   assign o_energized = i_contact;

   // Closing operations are counted, since contact wear limits the life of a relay load.
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         prev_r  <= 1'b0;
         o_n_ops <= 16'h0000;
      end else begin
         prev_r <= i_contact;
         if (i_contact && !prev_r) begin
            o_n_ops <= o_n_ops + 16'h0001;
         end
      end
   end
endmodule : lso_load_model

`default_nettype wire

// File: verification/testbench.sv
/*
 * Self-checking testbench of the limit switch output with its load model.
 * Assumes a 40 MHz clock and a short delay tick so that delays run in few cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
   localparam int TICK = 4;
   logic               clk;
   logic               srst;
   logic [3:0]         addr;
   logic [31:0]        wdata;
   logic               wr_en;
   logic               rd_en;
   logic signed [31:0] meas;
   logic signed [31:0] on_v;
   logic signed [31:0] off_v;
   logic               err;
   logic               diag;
   logic               dig;
   logic               lim;
   logic               closed;
   logic               energized;
   logic [31:0]        rd_data;
   logic [31:0]        seed;
   logic [31:0]        r;
   logic [15:0]        n_ops;
   logic [15:0]        ops0;
   logic               exp_b;
   int                 bad_count;
   int                 n_tests;

   lso_top #(.TICK_CYCLES(TICK)) lso_top_inst (.i_sys_clk(clk), .i_srst(srst), .i_addr(addr),
      .i_wr_data(wdata), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_meas_value(meas), .i_error(err),
      .i_diag_event(diag), .i_dig_out(dig), .o_rd_data(rd_data), .o_switch_closed(closed));

   lso_load_model lso_load_model_inst (.i_sys_clk(clk), .i_srst(srst), .i_contact(closed),
      .o_energized(energized), .o_n_ops(n_ops));

   // ==========================================================
   // Expectations
   // ==========================================================
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   function automatic logic lim_step(logic s, logic signed [31:0] on, logic signed [31:0] off,
                                     logic signed [31:0] m);
      if (on > off) return (m > on) ? 1'b1 : ((m < off) ? 1'b0 : s);
      return (m < on) ? 1'b1 : ((m > off) ? 1'b0 : s);
   endfunction : lim_step

   function automatic logic exp_out(int f, int fl, logic inv, logic e, logic dg, logic dd, logic l);
      logic o;
      case (f)
         0: o = 1'b0;
         1: o = 1'b1;
         2: o = !dg;
         3: o = l;
         default: o = dd;
      endcase
      if (e && f >= 3) o = (fl == 0) ? o : (fl == 2);
      return o ^ inv;
   endfunction : exp_out

   // ==========================================================
   // Compare and bus tasks
   // ==========================================================
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected contact at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_bit

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      chk_word(rd_data, exp);
   endtask : rd

   task automatic wait_out(input logic exp, input int bound);
      for (int i = 0; i < bound; i++) begin
         @(posedge clk);
         #1;
         if (energized === exp) break;
      end
      chk_bit(energized, exp);
   endtask : wait_out

   // Each threshold write lets the state settle, since the pair is not updated atomically.
   task automatic set_thr(input logic signed [31:0] on, input logic signed [31:0] off);
      on_v = on;
      wr(lso_pkg::OFS_ON_VAL, on);
      cyc(2);
      lim = lim_step(lim, on_v, off_v, meas);
      off_v = off;
      wr(lso_pkg::OFS_OFF_VAL, off);
      cyc(2);
      lim = lim_step(lim, on_v, off_v, meas);
      rd(lso_pkg::OFS_ON_VAL, on);
      rd(lso_pkg::OFS_OFF_VAL, off);
   endtask : set_thr

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test

   // ==========================================================
   // Clock, watchdog and sequence
   // ==========================================================
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      repeat (100000) @(posedge clk);
      bad_count++;
      finish_test();
   end

   initial begin
      srst      = 1'b1;
      addr      = 4'h0;
      wdata     = 32'h0000_0000;
      wr_en     = 1'b0;
      rd_en     = 1'b0;
      meas      = 32'sh0000_0000;
      err       = 1'b0;
      diag      = 1'b0;
      dig       = 1'b0;
      seed      = 32'h0000_96EB;
      lim       = 1'b0;
      on_v      = 32'sh0000_0000;
      off_v     = 32'sh0000_0000;
      ops0      = 16'h0000;
      exp_b     = 1'b0;
      bad_count = 0;
      n_tests   = 0;
      cyc(5);
      srst <= 1'b0;
      rd(lso_pkg::OFS_CTRL, 32'h0000_0010);
      rd(lso_pkg::OFS_ON_VAL, 32'h0000_0000);
      rd(lso_pkg::OFS_OFF_VAL, 32'h0000_0000);
      rd(lso_pkg::OFS_ON_DLY, 32'h0000_0000);
      rd(lso_pkg::OFS_OFF_DLY, 32'h0000_0000);
      rd(lso_pkg::OFS_STATUS, 32'h0000_0000);
      rd(4'hF, 32'h0000_0000);
      chk_bit(energized, 1'b0);
      // Every function, failure choice and inversion, with random error and source levels.
      for (int f = 0; f < 5; f++) begin
         for (int fl = 0; fl < 3; fl++) begin
            for (int inv = 0; inv < 2; inv++) begin
               wr(lso_pkg::OFS_CTRL, 32'(f) | (32'(fl) << 4) | (32'(inv) << 8));
               r = xs();
               err  <= r[0];
               diag <= r[1];
               dig  <= r[2];
               cyc(3);
               #1;
               exp_b = exp_out(f, fl, inv[0], r[0], r[1], r[2], 1'b0);
               chk_bit(energized, exp_b);
               rd(lso_pkg::OFS_STATUS, {29'h0000_0000, r[0], 1'b0, exp_b});
            end
         end
      end
      @(posedge clk);
      err <= 1'b0;
      wr(lso_pkg::OFS_CTRL, 32'h0000_0035);
      rd(lso_pkg::OFS_CTRL, 32'h0000_0024);
      // Delays: bounds, clamp and a cancelled pending change.
      wr(lso_pkg::OFS_CTRL, 32'h0000_0013);
      set_thr(32'sd10, -32'sd10);
      wr(lso_pkg::OFS_ON_DLY, 32'h0000_03FF);
      rd(lso_pkg::OFS_ON_DLY, 32'(lso_pkg::DLY_MAX));
      wr(lso_pkg::OFS_ON_DLY, 32'h0000_0003);
      ops0 = n_ops;
      meas <= 32'sd20;
      cyc(6);
      #1;
      chk_bit(energized, 1'b0);
      wait_out(1'b1, 12);
      wr(lso_pkg::OFS_OFF_DLY, 32'h0000_0003);
      chk_word({16'h0000, n_ops}, {16'h0000, 16'(ops0 + 16'h0001)});
      meas <= -32'sd20;
      cyc(6);
      meas <= 32'sd0;
      cyc(20);
      #1;
      chk_bit(energized, 1'b1);
      @(posedge clk);
      meas <= -32'sd20;
      cyc(6);
      #1;
      chk_bit(energized, 1'b1);
      wait_out(1'b0, 12);
      // Random thresholds in both orders, with equal thresholds as a corner.
      wr(lso_pkg::OFS_ON_DLY, 32'h0000_0000);
      wr(lso_pkg::OFS_OFF_DLY, 32'h0000_0000);
      lim = 1'b0;
      for (int i = 0; i < 60; i++) begin
         r = xs();
         if (i == 30) set_thr(32'sd5, 32'sd5);
         else if (i % 6 == 0) set_thr($signed(r[4:0]), $signed(r[9:5]));
         @(posedge clk);
         meas <= $signed(r[15:10]);
         cyc(3);
         lim = lim_step(lim, on_v, off_v, meas);
         #1;
         chk_bit(energized, lim);
         rd(lso_pkg::OFS_STATUS, {30'h0000_0000, lim, lim});
      end
      finish_test();
   end
endmodule : testbench

`default_nettype wire
